// ### src/drive_comm_defines.vh
// register map, function codes, exception codes and limits of the drive's
// communication register bank; included by every design file of the bank
`ifndef DRIVE_COMM_DEFINES_VH
`define DRIVE_COMM_DEFINES_VH

// function codes taken from the frame layer
`define FUNC_READ 8'h03
`define FUNC_WRITE 8'h06
`define FUNC_EXC_FLAG 8'h80

// exception causes
`define EXC_BAD_COMMAND 8'h01
`define EXC_BAD_ADDRESS 8'h02
`define EXC_OP_FAILURE 8'h04
`define EXC_READ_ONLY 8'h07

// register addresses
`define ADDR_AO_SET_A 16'h200D
`define ADDR_AO_SET_B 16'h200E
`define ADDR_RUN_STATE 16'h2100
`define ADDR_DRIVE_FLAGS 16'h2101
`define ADDR_FAULT_TYPE 16'h2102
`define ADDR_IDENT 16'h2103
`define ADDR_ACT_FREQ 16'h3000
`define ADDR_TGT_FREQ 16'h3001
`define ADDR_DC_LINK 16'h3002
`define ADDR_MOTOR_VOLT 16'h3003
`define ADDR_MOTOR_CURR 16'h3004
`define ADDR_SPEED 16'h3005
`define ADDR_POWER 16'h3006
`define ADDR_TORQUE 16'h3007
`define ADDR_LOOP_REF 16'h3008
`define ADDR_LOOP_MEAS 16'h3009
`define ADDR_DIN 16'h300A
`define ADDR_DOUT 16'h300B
`define ADDR_AIN_A 16'h300C
`define ADDR_AIN_B 16'h300D
`define ADDR_AIN_C 16'h300E
`define ADDR_AIN_D 16'h300F
`define ADDR_PULSE_A 16'h3010
`define ADDR_PULSE_B 16'h3011
`define ADDR_STEP 16'h3012
`define ADDR_LENGTH 16'h3013
`define ADDR_EVENTS 16'h3014
`define ADDR_TORQUE_REF 16'h3015
`define ADDR_LEGACY_IDENT 16'h3016
`define ADDR_LEGACY_FAULT 16'h5000

// value limits in fieldbus units (scale 10 for one decimal)
`define AO_FULL_SCALE 16'h03E8
`define DC_LINK_MAX 16'h4E20
`define POWER_LIMIT 16'h0BB8
`define AO_RESET 16'h0000

// run state codes
`define RUN_FWD 16'h0001
`define RUN_REV 16'h0002
`define RUN_STOPPED 16'h0003
`define RUN_FAULTED 16'h0004
`define RUN_POWER_OFF 16'h0005
`define RUN_PREEXCITED 16'h0006

// status word 2 field positions
`define FLAG_READY_BIT 0
`define FLAG_MOTOR_LSB 1
`define FLAG_SYNC_BIT 3
`define FLAG_OVERLOAD_BIT 4
`define FLAG_SOURCE_LSB 5

// source parameter encodings
`define SRC_KEYPAD 2'h0
`define SRC_TERMINAL 2'h1
`define SRC_COMM 2'h2
`define COMM_CHANNEL_MODBUS 2'h0
`define PID_SRC_MODBUS 4'h5

`endif

// ### src/drive_status_words.v
// packs the drive's live state into the two status words
// assumes all state inputs are synchronous levels from the drive core
`timescale 1ns/1ps
`include "drive_comm_defines.vh"

module drive_status_words (
  // drive state
  input wire running,
  input wire reverse,
  input wire faulted,
  input wire undervoltage_off_state,
  input wire pre_excited,
  input wire ready_to_run,
  input wire [1:0] active_motor,
  input wire motor_is_sync,
  input wire overload_alarm,
  input wire [1:0] run_command_source_param,
  // packed words
  output reg [15:0] run_state_word,
  output reg [15:0] drive_flags_word
);

  // loss of supply outranks a fault, which outranks the normal states
  always @* begin
    if (undervoltage_off_state) begin
      run_state_word = `RUN_POWER_OFF;
    end else if (faulted) begin
      run_state_word = `RUN_FAULTED;
    end else if (pre_excited) begin
      run_state_word = `RUN_PREEXCITED;
    end else if (running) begin
      run_state_word = reverse ? `RUN_REV : `RUN_FWD;
    end else begin
      run_state_word = `RUN_STOPPED;
    end
  end

  always @* begin
    drive_flags_word = 16'h0000;
    drive_flags_word[`FLAG_READY_BIT] = ready_to_run;
    drive_flags_word[`FLAG_MOTOR_LSB +: 2] = active_motor;
    drive_flags_word[`FLAG_SYNC_BIT] = motor_is_sync;
    drive_flags_word[`FLAG_OVERLOAD_BIT] = overload_alarm;
    drive_flags_word[`FLAG_SOURCE_LSB +: 2] = run_command_source_param;
  end

endmodule // drive_status_words

// ### src/drive_comm_register_map.v
// communication register bank of the drive: decodes one read or write
// request per pulse from the frame layer and answers one cycle later
// assumes the frame layer has checked framing and delivers one request at a time
`timescale 1ns/1ps
`include "drive_comm_defines.vh"

module drive_comm_register_map #(
  // arbitrary identity values, not those of any real product
  parameter [7:0] FAMILY_CODE = 8'h5A,
  parameter [7:0] MODEL_CODE = 8'h3C
) (
  // clock and reset
  input wire core_clk,
  input wire rstn,
  // request from the frame layer
  input wire req_valid,
  input wire [7:0] req_func,
  input wire [15:0] req_addr,
  input wire [15:0] req_wdata,
  // answer to the frame layer
  output reg rsp_valid,
  output reg [7:0] rsp_func,
  output reg rsp_exception,
  output reg [7:0] rsp_exc_code,
  output reg [15:0] rsp_data,
  // drive state
  input wire running,
  input wire reverse,
  input wire faulted,
  input wire undervoltage_off_state,
  input wire pre_excited,
  input wire ready_to_run,
  input wire [1:0] active_motor,
  input wire motor_is_sync,
  input wire overload_alarm,
  input wire [15:0] fault_type,
  // source parameters
  input wire [1:0] run_command_source_param,
  input wire [1:0] comm_run_channel_param,
  input wire [3:0] pid_reference_source_param,
  // measurements, already in fieldbus units
  input wire [15:0] actual_frequency,
  input wire [15:0] target_frequency,
  input wire [15:0] dc_link_voltage,
  input wire [15:0] motor_voltage,
  input wire [15:0] motor_current,
  input wire [15:0] shaft_speed,
  input wire [15:0] delivered_power,
  input wire [15:0] delivered_torque,
  input wire [15:0] loop_reference,
  input wire [15:0] loop_measured,
  input wire [15:0] digital_inputs_state,
  input wire [15:0] digital_outputs_state,
  input wire [15:0] analog_in_a,
  input wire [15:0] analog_in_b,
  input wire [15:0] analog_in_c,
  input wire [15:0] analog_in_d,
  input wire [15:0] pulse_in_freq_a,
  input wire [15:0] pulse_in_freq_b,
  input wire [15:0] speed_step_index,
  input wire [15:0] length_counter,
  input wire [15:0] event_counter,
  input wire [15:0] torque_reference,
  // outputs to the drive core
  output reg [15:0] analog_out_setpoint_a,
  output reg [15:0] analog_out_setpoint_b,
  output wire comm_run_enable,
  output wire comm_pid_enable
);

  wire [15:0] run_state_word;
  wire [15:0] drive_flags_word;
  wire [15:0] product_ident;
  wire [15:0] dc_link_capped;
  wire [15:0] power_capped;
  reg [15:0] next_rdata;
  reg next_mapped;
  reg next_writable;
  reg [7:0] next_exc_code;
  reg next_exc;
  reg next_write_a;
  reg next_write_b;

  // true when a signed word lies within -limit..+limit
  function in_signed_range;
    input [15:0] value;
    input [15:0] limit;
    begin
      if (value[15]) begin
        in_signed_range = ((~value + 16'h0001) <= limit);
      end else begin
        in_signed_range = (value <= limit);
      end
    end
  endfunction

  // clamps a signed word to -limit..+limit so a runaway sensor never
  // reads back outside the documented span
  function [15:0] clamp_signed;
    input [15:0] value;
    input [15:0] limit;
    begin
      if (in_signed_range(value, limit)) begin
        clamp_signed = value;
      end else if (value[15]) begin
        clamp_signed = ~limit + 16'h0001;
      end else begin
        clamp_signed = limit;
      end
    end
  endfunction

  drive_status_words status_words (
    .running(running),
    .reverse(reverse),
    .faulted(faulted),
    .undervoltage_off_state(undervoltage_off_state),
    .pre_excited(pre_excited),
    .ready_to_run(ready_to_run),
    .active_motor(active_motor),
    .motor_is_sync(motor_is_sync),
    .overload_alarm(overload_alarm),
    .run_command_source_param(run_command_source_param),
    .run_state_word(run_state_word),
    .drive_flags_word(drive_flags_word)
  );

  assign product_ident = {FAMILY_CODE, MODEL_CODE};

  // values arrive pre-scaled: 0.1 V and 0.1 percent steps
  assign dc_link_capped = (dc_link_voltage > `DC_LINK_MAX) ?
    `DC_LINK_MAX : dc_link_voltage;
  assign power_capped = clamp_signed(delivered_power, `POWER_LIMIT);

  // commands from the link only steer the drive once the source selects it
  assign comm_run_enable = (run_command_source_param == `SRC_COMM) &&
    (comm_run_channel_param == `COMM_CHANNEL_MODBUS);
  assign comm_pid_enable = (pid_reference_source_param == `PID_SRC_MODBUS);

  // address decode and read data
  always @* begin
    next_mapped = 1'b1;
    next_writable = 1'b0;
    next_rdata = 16'h0000;
    case (req_addr)
      `ADDR_AO_SET_A: begin
        next_writable = 1'b1;
        next_rdata = analog_out_setpoint_a;
      end
      `ADDR_AO_SET_B: begin
        next_writable = 1'b1;
        next_rdata = analog_out_setpoint_b;
      end
      `ADDR_RUN_STATE: next_rdata = run_state_word;
      `ADDR_DRIVE_FLAGS: next_rdata = drive_flags_word;
      `ADDR_FAULT_TYPE: next_rdata = fault_type;
      `ADDR_IDENT: next_rdata = product_ident;
      `ADDR_ACT_FREQ: next_rdata = actual_frequency;
      `ADDR_TGT_FREQ: next_rdata = target_frequency;
      `ADDR_DC_LINK: next_rdata = dc_link_capped;
      `ADDR_MOTOR_VOLT: next_rdata = motor_voltage;
      `ADDR_MOTOR_CURR: next_rdata = motor_current;
      `ADDR_SPEED: next_rdata = shaft_speed;
      `ADDR_POWER: next_rdata = power_capped;
      `ADDR_TORQUE: next_rdata = delivered_torque;
      `ADDR_LOOP_REF: next_rdata = loop_reference;
      `ADDR_LOOP_MEAS: next_rdata = loop_measured;
      `ADDR_DIN: next_rdata = digital_inputs_state;
      `ADDR_DOUT: next_rdata = digital_outputs_state;
      `ADDR_AIN_A: next_rdata = analog_in_a;
      `ADDR_AIN_B: next_rdata = analog_in_b;
      `ADDR_AIN_C: next_rdata = analog_in_c;
      `ADDR_AIN_D: next_rdata = analog_in_d;
      `ADDR_PULSE_A: next_rdata = pulse_in_freq_a;
      `ADDR_PULSE_B: next_rdata = pulse_in_freq_b;
      `ADDR_STEP: next_rdata = speed_step_index;
      `ADDR_LENGTH: next_rdata = length_counter;
      `ADDR_EVENTS: next_rdata = event_counter;
      `ADDR_TORQUE_REF: next_rdata = torque_reference;
      `ADDR_LEGACY_IDENT: next_rdata = product_ident;
      `ADDR_LEGACY_FAULT: next_rdata = fault_type;
      default: next_mapped = 1'b0;
    endcase
  end

  // request checking; the first failing check names the cause
  always @* begin
    next_exc = 1'b0;
    next_exc_code = 8'h00;
    next_write_a = 1'b0;
    next_write_b = 1'b0;
    if (req_func != `FUNC_READ && req_func != `FUNC_WRITE) begin
      next_exc = 1'b1;
      next_exc_code = `EXC_BAD_COMMAND;
    end else if (!next_mapped) begin
      next_exc = 1'b1;
      next_exc_code = `EXC_BAD_ADDRESS;
    end else if (req_func == `FUNC_WRITE) begin
      if (!next_writable) begin
        next_exc = 1'b1;
        next_exc_code = `EXC_READ_ONLY;
      end else if (!in_signed_range(req_wdata, `AO_FULL_SCALE)) begin
        // out of span is refused rather than clipped, so the master learns
        next_exc = 1'b1;
        next_exc_code = `EXC_OP_FAILURE;
      end else begin
        next_write_a = (req_addr == `ADDR_AO_SET_A);
        next_write_b = (req_addr == `ADDR_AO_SET_B);
      end
    end
  end

  // setpoint storage
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      analog_out_setpoint_a <= `AO_RESET;
      analog_out_setpoint_b <= `AO_RESET;
    end else if (req_valid) begin
      if (next_write_a) begin
        analog_out_setpoint_a <= req_wdata;
      end
      if (next_write_b) begin
        analog_out_setpoint_b <= req_wdata;
      end
    end
  end

  // answer, one cycle after the request
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rsp_valid <= 1'b0;
      rsp_func <= 8'h00;
      rsp_exception <= 1'b0;
      rsp_exc_code <= 8'h00;
      rsp_data <= 16'h0000;
    end else begin
      rsp_valid <= req_valid;
      if (req_valid) begin
        rsp_exception <= next_exc;
        rsp_exc_code <= next_exc_code;
        rsp_func <= next_exc ? (req_func | `FUNC_EXC_FLAG) : req_func;
        if (next_exc) begin
          rsp_data <= 16'h0000;
        end else if (req_func == `FUNC_WRITE) begin
          rsp_data <= req_wdata;
        end else begin
          rsp_data <= next_rdata;
        end
      end
    end
  end

endmodule // drive_comm_register_map

// ### dv/drive_comm_register_map_assertions.sv
// timing and content checks on the register bank's request and answer ports
// assumes binding into the bank, one clock, reset active low
`timescale 1ns/1ps
module drive_comm_register_map_assertions #(
  parameter [7:0] FAMILY_CODE = 8'h5A,
  parameter [7:0] MODEL_CODE = 8'h3C
) (
  // clock and reset
  input wire core_clk,
  input wire rstn,
  // request
  input wire req_valid,
  input wire [7:0] req_func,
  input wire [15:0] req_addr,
  input wire [15:0] req_wdata,
  // answer
  input wire rsp_valid,
  input wire [7:0] rsp_func,
  input wire rsp_exception,
  input wire [7:0] rsp_exc_code,
  input wire [15:0] rsp_data,
  // drive state and sources
  input wire ready_to_run,
  input wire [15:0] fault_type,
  input wire [1:0] run_command_source_param,
  input wire [1:0] comm_run_channel_param,
  input wire [3:0] pid_reference_source_param,
  // outputs to the core
  input wire [15:0] analog_out_setpoint_a,
  input wire comm_run_enable,
  input wire comm_pid_enable
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  AST_ANSWER_NEXT: assert property (req_valid |=> rsp_valid)
    else $error("request not answered next cycle");
  AST_NO_SPURIOUS: assert property (!req_valid |=> !rsp_valid)
    else $error("answer without request");
  AST_EXC_FUNC: assert property (
    rsp_valid && rsp_exception |-> rsp_func == ($past(req_func) | 8'h80))
    else $error("exception function code wrong");
  AST_RO_WRITE: assert property (req_valid && req_func == 8'h06 &&
    req_addr inside {[16'h2100:16'h2103], [16'h3000:16'h3016], 16'h5000}
    |=> rsp_exception && rsp_exc_code == 8'h07)
    else $error("read-only write not refused");
  AST_IDENT: assert property (
    req_valid && req_func == 8'h03 && req_addr == 16'h2103
    |=> rsp_data == {FAMILY_CODE, MODEL_CODE})
    else $error("ident wrong");
  AST_READY: assert property (
    req_valid && req_func == 8'h03 && req_addr == 16'h2101
    |=> rsp_data[0] == $past(ready_to_run))
    else $error("ready bit wrong");
  AST_FAULT: assert property (
    req_valid && req_func == 8'h03 && req_addr == 16'h2102
    |=> rsp_data == $past(fault_type))
    else $error("fault type wrong");
  AST_SETPOINT: assert property (req_valid && req_func == 8'h06 &&
    req_addr == 16'h200D && $signed(req_wdata) <= 1000 && $signed(req_wdata) >= -1000
    |=> analog_out_setpoint_a == $past(req_wdata) && !rsp_exception)
    else $error("setpoint write lost");
  AST_ENABLES: assert property (
    comm_run_enable == (run_command_source_param == 2'h2 && comm_run_channel_param == 2'h0)
    && comm_pid_enable == (pid_reference_source_param == 4'h5))
    else $error("enable wrong");
  cover property (req_valid && req_func == 8'h06 ##1 !rsp_exception);
  cover property (rsp_valid && rsp_exc_code == 8'h04);
  cover property (rsp_valid && rsp_exc_code == 8'h07);
endmodule // drive_comm_register_map_assertions

// ### dv/modbus_master_model.sv
// master on the frame side: one single-word request per call
// assumes the answer stands just after the edge that takes the request
`timescale 1ns/1ps
module modbus_master_model (
  // clock
  input wire core_clk,
  // request
  output logic req_valid,
  output logic [7:0] req_func,
  output logic [15:0] req_addr,
  output logic [15:0] req_wdata,
  // answer
  input wire rsp_valid
);
  initial begin
    req_valid = 1'b0;
    req_func = 8'h00;
    req_addr = 16'h0000;
    req_wdata = 16'h0000;
  end
  task automatic xfer(input logic [7:0] f, input logic [15:0] a, input logic [15:0] w,
                      output logic got);
    @(posedge core_clk);
    #1;
    req_valid = 1'b1;
    req_func = f;
    req_addr = a;
    req_wdata = w;
    @(posedge core_clk);
    #1;
    got = rsp_valid;
    req_valid = 1'b0;
    // released qualifiers are inverted so a stale value cannot pass
    req_func = ~f;
    req_addr = ~a;
    req_wdata = ~w;
  endtask
endmodule // modbus_master_model

// ### dv/drive_comm_register_map_test.sv
// self-checking bench of the drive communication register bank
// assumes the master model and the checker are compiled first
`timescale 1ns/1ps
module drive_comm_register_map_test;
  localparam [7:0] FAM = 8'hA5; // arbitrary
  localparam [7:0] MOD = 8'h17; // arbitrary
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic req_valid, rsp_valid, rsp_exception, comm_run_enable, comm_pid_enable, got;
  logic [7:0] req_func, rsp_func, rsp_exc_code, f;
  logic [15:0] req_addr, req_wdata, rsp_data, a, w;
  logic [15:0] analog_out_setpoint_a, analog_out_setpoint_b;
  logic [15:0] sa = 16'h0000;
  logic [15:0] sb = 16'h0000;
  logic [15:0] actual_frequency, target_frequency, dc_link_voltage, motor_voltage,
    motor_current, shaft_speed, delivered_power, delivered_torque, loop_reference,
    loop_measured, digital_inputs_state, digital_outputs_state, analog_in_a, analog_in_b,
    analog_in_c, analog_in_d, pulse_in_freq_a, pulse_in_freq_b, speed_step_index,
    length_counter, event_counter, torque_reference, fault_type;
  logic running, reverse, faulted, undervoltage_off_state, pre_excited, ready_to_run;
  logic motor_is_sync, overload_alarm;
  logic [1:0] active_motor, run_command_source_param, comm_run_channel_param;
  logic [3:0] pid_reference_source_param;
  logic [351:0] mv = '0;
  logic [33:0] st = '0;
  logic [15:0] corner [4] = '{16'h03E8, 16'hFC18, 16'h03E9, 16'hFC17};
  int seed = 32'h85b5b407;
  int failures = 0;
  int n_compared = 0;
  int i, j, k, r;
  assign {actual_frequency, target_frequency, dc_link_voltage, motor_voltage,
    motor_current, shaft_speed, delivered_power, delivered_torque, loop_reference,
    loop_measured, digital_inputs_state, digital_outputs_state, analog_in_a, analog_in_b,
    analog_in_c, analog_in_d, pulse_in_freq_a, pulse_in_freq_b, speed_step_index,
    length_counter, event_counter, torque_reference} = mv;
  assign {running, reverse, faulted, undervoltage_off_state, pre_excited, ready_to_run,
    motor_is_sync, overload_alarm, active_motor, run_command_source_param,
    comm_run_channel_param, pid_reference_source_param, fault_type} = st;
  always #12.5 core_clk = ~core_clk;
  drive_comm_register_map #(.FAMILY_CODE(FAM), .MODEL_CODE(MOD))
    drive_comm_register_map_inst (.*);
  modbus_master_model modbus_master_model_inst (.*);
  task automatic stop_test();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  // returns {exception, cause, data}
  function automatic logic [24:0] exp_rsp(logic [7:0] fc, logic [15:0] ad, logic [15:0] wd);
    logic [15:0] d;
    d = 16'h0000;
    if (fc != 8'h03 && fc != 8'h06)
      return {9'h101, d};
    if (!(ad inside {16'h200D, 16'h200E, [16'h2100:16'h2103], [16'h3000:16'h3016], 16'h5000}))
      return {9'h102, d};
    if (fc == 8'h06 && ad != 16'h200D && ad != 16'h200E)
      return {9'h107, d};
    if (fc == 8'h06)
      return ($signed(wd) > 1000 || $signed(wd) < -1000) ? {9'h104, d} : {9'h000, wd};
    if (ad == 16'h2100)
      d = undervoltage_off_state ? 16'h0005 : faulted ? 16'h0004 : pre_excited ? 16'h0006 :
        running ? (reverse ? 16'h0002 : 16'h0001) : 16'h0003;
    else if (ad == 16'h2101)
      d = {9'h000, run_command_source_param, overload_alarm, motor_is_sync,
        active_motor, ready_to_run};
    else if (ad == 16'h2102 || ad == 16'h5000)
      d = fault_type;
    else if (ad == 16'h2103 || ad == 16'h3016)
      d = {FAM, MOD};
    else if (ad == 16'h200D || ad == 16'h200E)
      d = ad[0] ? sa : sb;
    else
      d = mv[(21 - ad[4:0]) * 16 +: 16];
    if (ad == 16'h3002 && d > 16'd20000)
      d = 16'd20000;
    if (ad == 16'h3006)
      d = $signed(d) > 3000 ? 16'd3000 : $signed(d) < -3000 ? -16'sd3000 : d;
    return {9'h000, d};
  endfunction
  task automatic send(input logic [7:0] fc, input logic [15:0] ad, input logic [15:0] wd);
    logic [24:0] e;
    // expectation is worked out once the state nets have settled to the new stimulus
    modbus_master_model_inst.xfer(fc, ad, wd, got);
    e = exp_rsp(fc, ad, wd);
    check(got, 1'b1);
    check(rsp_exception, e[24]);
    check(rsp_exc_code, e[23:16]);
    check(rsp_func, e[24] ? (fc | 8'h80) : fc);
    check(rsp_data, e[15:0]);
    if (!e[24] && fc == 8'h06)
      {sa, sb} = ad[0] ? {wd, sb} : {sa, wd};
    check(analog_out_setpoint_a, sa);
    check(analog_out_setpoint_b, sb);
    check(comm_run_enable, run_command_source_param == 2'h2 && comm_run_channel_param == 2'h0);
    check(comm_pid_enable, pid_reference_source_param == 4'h5);
  endtask
  initial begin
    #(25 * 20000);
    failures++;
    stop_test();
  end
  initial begin
    repeat (6) @(posedge core_clk);
    #1;
    rstn = 1'b1;
    check(rsp_valid, 1'b0);
    // each end of the setpoint range, then one step beyond it
    for (i = 0; i < 8; i++) begin
      send(8'h06, 16'h200D + i[0], corner[i / 2]);
      send(8'h03, 16'h200D + i[0], 16'h0000);
    end
    send(8'h06, 16'h2100, 16'h1234);
    send(8'h05, 16'h3016, 16'h0000);
    $display("test corners done");
    for (i = 0; i < 500; i++) begin
      @(posedge core_clk);
      #1;
      for (j = 0; j < 11; j++)
        mv[j * 32 +: 32] = $random(seed);
      st[31:0] = $random(seed);
      r = $random(seed);
      st[33:32] = r[1:0];
      k = $random(seed) % 1101;
      w = k[15:0];
      f = (r[4:2] < 5) ? 8'h03 : (r[4:2] < 7) ? 8'h06 : r[15:8];
      case (r[6:5])
        2'd0: a = 16'h200D + r[7];
        2'd1: a = 16'h2100 + r[10:8] % 5;
        2'd2: a = 16'h3000 + r[20:16] % 24;
        default: a = 16'h5000 + r[7];
      endcase
      send(f, a, w);
    end
    $display("test random done");
    @(posedge core_clk);
    #1;
    rstn = 1'b0;
    {sa, sb} = 32'h0000_0000;
    @(posedge core_clk);
    #1;
    rstn = 1'b1;
    send(8'h03, 16'h2103, 16'h0000);
    $display("test second reset done");
    stop_test();
  end
endmodule // drive_comm_register_map_test
bind drive_comm_register_map drive_comm_register_map_assertions
  #(.FAMILY_CODE(FAMILY_CODE), .MODEL_CODE(MODEL_CODE))
  drive_comm_register_map_assertions_inst (.*);
